/* rtl/dlp_map.svh */
// Register offsets, field positions, reset values and timing figures of the DAC control block
`ifndef DLP_MAP_SVH
`define DLP_MAP_SVH
// Byte addresses of the APB registers
`define DLP_OFF_CODE0 8'h00
`define DLP_OFF_CODE1 8'h04
`define DLP_OFF_PD 8'h08
`define DLP_OFF_CFG 8'h0C
`define DLP_OFF_STAT 8'h10
`define DLP_OFF_CMD 8'h14
`define DLP_OFF_WIPER0 8'h18
`define DLP_OFF_WIPER1 8'h1C
`define DLP_OFF_IRQ_STAT 8'h20
`define DLP_OFF_IRQ_MASK 8'h24
// Field widths and positions
`define DLP_CODE_W 12
`define DLP_CFG_W 5
`define DLP_IRQ_W 4
`define DLP_PD_CH1_LSB 2
`define DLP_STAT_POR_BIT 0
`define DLP_STAT_BUSY_BIT 1
`define DLP_STAT_PTR_LSB 8
`define DLP_CMD_GC_RESET_BIT 0
`define DLP_CMD_GC_WAKE_BIT 1
`define DLP_IRQ_WIPER_BIT 0
`define DLP_IRQ_PD_ENTRY_BIT 1
`define DLP_IRQ_PD_EXIT_BIT 2
`define DLP_IRQ_GC_RESET_BIT 3
// Power-on default values
`define DLP_CODE_RST 12'h7FF
`define DLP_CFG_RST 5'h00
`define DLP_PD_RST 2'h0
`define DLP_IRQ_MASK_RST 4'h0
// Power-on delay before the output stage may drive
`define DLP_POR_DELAY_NS 1000
`define DLP_CLK_PERIOD_NS 25
`endif

/* rtl/dlp_pkg.sv */
// Types shared by the DAC latch and power-down control block
package dlp_pkg;
   // Power-down selector settings, in selector encoding order
   typedef enum logic [1:0] {
      DLP_PD_NORMAL,
      DLP_PD_1K,
      DLP_PD_100K,
      DLP_PD_OPEN
   } dlp_pd_e;
   // APB slave phase
   typedef enum logic [0:0] {
      DLP_BUS_IDLE,
      DLP_BUS_ANSWER
   } dlp_bus_e;
   // Output stage controls of one channel: amp, ladder, 1k, 100k
   typedef logic [3:0] dlp_stage_t;
endpackage : dlp_pkg

/* rtl/dlp_ctrl.sv */
// DAC latch, wiper transfer and power-down control with an APB register slave
//
// How it works
// - Hold pin high freezes wipers, writes accepted
// - Hold pin low: wipers follow code registers
// - Hold pin acts independent of bus transfers
// - Both wipers load together on hold release
// - Selector: normal, 1k, 100k, open
// - Each channel owns its power-down selector
// - Power-down cuts amp and ladder, keeps registers
// - Selector changes by write, general call or power-on only
// - Write and general call commands update selector
// - Write of 00, wake-up, reset exit power-down
// - Register interface stays active in power-down
// - General call reset: codes, selectors, config, pointer to defaults, no delay
// - Power-up loads defaults, then software may overwrite
// - Five config bits, two status, 12-bit codes
// - Power-on flag set, cleared by status read
// - Power-on resets bus state and address pointer
`timescale 1ns/1ps
`include "dlp_map.svh"

module dlp_ctrl
   import dlp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic update_hold_pin,
   output logic [11:0] wiper0,
   output logic [11:0] wiper1,
   output logic [1:0] amp_en,
   output logic [1:0] ladder_en,
   output logic [1:0] pull_1k_en,
   output logic [1:0] pull_100k_en,
   output logic [4:0] cfg_bits,
   output logic irq
);

   // Power-on delay in cycles, rounded up
   localparam int POR_CYC = (`DLP_POR_DELAY_NS + `DLP_CLK_PERIOD_NS - 1) / `DLP_CLK_PERIOD_NS;
   localparam logic [7:0] POR_CNT_INIT = 8'(POR_CYC);

   // Output stage decode for one selector value
   function automatic dlp_stage_t stage_of(input logic [1:0] sel, input logic busy);
      dlp_stage_t s;
      s = 4'h0;
      case (dlp_pd_e'(sel))
         DLP_PD_NORMAL: s = {~busy, ~busy, 1'b0, 1'b0};
         DLP_PD_1K: s = 4'h2;
         DLP_PD_100K: s = 4'h1;
         DLP_PD_OPEN: s = 4'h0;
         default: s = 4'h0;
      endcase
      return s;
   endfunction : stage_of

   // Bus slave state
   dlp_bus_e bus_r; // Answer phase marker
   logic [31:0] prdata_r; // Registered read data
   logic pslverr_r; // Registered error answer
   logic [7:0] addr_ptr_r; // Last address taken
   // Stored registers
   logic [11:0] code_r [2]; // Volatile code registers
   logic [11:0] wiper_r [2]; // Wiper registers
   logic [1:0] pd_r [2]; // Power-down selectors
   logic [4:0] cfg_r; // Configuration bits
   logic por_flag_r; // Power-on status flag
   logic [7:0] por_cnt_r; // Power-on delay counter
   logic [3:0] irq_stat_r; // Sticky event bits
   logic [3:0] irq_mask_r; // Event enables
   logic irq_r; // Interrupt output
   dlp_stage_t stage_r [2]; // Registered output stage controls
   // Hold pin synchroniser
   logic hold_s1_r;
   logic hold_s2_r;

   // Bus decode
   wire acc_req = psel && penable && (bus_r == DLP_BUS_IDLE);
   wire acc_done = psel && penable && (bus_r == DLP_BUS_ANSWER);
   wire wr_done = acc_done && pwrite;
   wire rd_done = acc_done && !pwrite;
   wire sel_code0 = (paddr == `DLP_OFF_CODE0);
   wire sel_code1 = (paddr == `DLP_OFF_CODE1);
   wire sel_pd = (paddr == `DLP_OFF_PD);
   wire sel_cfg = (paddr == `DLP_OFF_CFG);
   wire sel_stat = (paddr == `DLP_OFF_STAT);
   wire sel_cmd = (paddr == `DLP_OFF_CMD);
   wire sel_wip0 = (paddr == `DLP_OFF_WIPER0);
   wire sel_wip1 = (paddr == `DLP_OFF_WIPER1);
   wire sel_istat = (paddr == `DLP_OFF_IRQ_STAT);
   wire sel_imask = (paddr == `DLP_OFF_IRQ_MASK);
   wire mapped = sel_code0 | sel_code1 | sel_pd | sel_cfg | sel_stat | sel_cmd
      | sel_wip0 | sel_wip1 | sel_istat | sel_imask;

   // General call commands issued through the command register
   wire gc_reset = wr_done && sel_cmd && pwdata[`DLP_CMD_GC_RESET_BIT];
   wire gc_wake = wr_done && sel_cmd && pwdata[`DLP_CMD_GC_WAKE_BIT];
   wire por_busy = (por_cnt_r != 8'h00);
   wire hold_now = hold_s2_r;

   // Read data mux
   wire [31:0] stat_word = {16'h0000, addr_ptr_r, 6'h00, por_busy, por_flag_r};
   wire [31:0] rd_word =
      sel_code0 ? {20'h00000, code_r[0]} :
      sel_code1 ? {20'h00000, code_r[1]} :
      sel_pd ? {28'h0000000, pd_r[1], pd_r[0]} :
      sel_cfg ? {27'h0000000, cfg_r} :
      sel_stat ? stat_word :
      sel_wip0 ? {20'h00000, wiper_r[0]} :
      sel_wip1 ? {20'h00000, wiper_r[1]} :
      sel_istat ? {28'h0000000, irq_stat_r} :
      sel_imask ? {28'h0000000, irq_mask_r} : 32'h00000000;

   // Next values of the code registers; a write lands only when the transfer completes
   wire [11:0] code0_nxt = gc_reset ? `DLP_CODE_RST :
      (wr_done && sel_code0) ? pwdata[11:0] : code_r[0];
   wire [11:0] code1_nxt = gc_reset ? `DLP_CODE_RST :
      (wr_done && sel_code1) ? pwdata[11:0] : code_r[1];
   // Selector sources: register write, wake-up and reset only
   wire pd_wr = wr_done && sel_pd;
   wire [1:0] pd0_nxt = (gc_reset || gc_wake) ? `DLP_PD_RST :
      pd_wr ? pwdata[1:0] : pd_r[0];
   wire [1:0] pd1_nxt = (gc_reset || gc_wake) ? `DLP_PD_RST :
      pd_wr ? pwdata[`DLP_PD_CH1_LSB +: 2] : pd_r[1];
   // Wipers follow codes while the synchronised hold level is low
   wire [11:0] wiper0_nxt = hold_now ? wiper_r[0] : code_r[0];
   wire [11:0] wiper1_nxt = hold_now ? wiper_r[1] : code_r[1];
   // Events for the interrupt status
   wire [3:0] irq_set;
   assign irq_set[`DLP_IRQ_WIPER_BIT] = (wiper0_nxt != wiper_r[0]) || (wiper1_nxt != wiper_r[1]);
   assign irq_set[`DLP_IRQ_PD_ENTRY_BIT] = ((pd_r[0] == `DLP_PD_RST) && (pd0_nxt != `DLP_PD_RST))
      || ((pd_r[1] == `DLP_PD_RST) && (pd1_nxt != `DLP_PD_RST));
   assign irq_set[`DLP_IRQ_PD_EXIT_BIT] = ((pd_r[0] != `DLP_PD_RST) && (pd0_nxt == `DLP_PD_RST))
      || ((pd_r[1] != `DLP_PD_RST) && (pd1_nxt == `DLP_PD_RST));
   assign irq_set[`DLP_IRQ_GC_RESET_BIT] = gc_reset;
   // Set wins over a write-one clear in the same cycle
   wire [3:0] irq_clr = (wr_done && sel_istat) ? pwdata[3:0] : 4'h0;
   wire [3:0] irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);
   // New mask acts on the output in the same cycle it is written, with no extra lag
   wire [3:0] irq_mask_nxt = (wr_done && sel_imask) ? pwdata[3:0] : irq_mask_r;

   // Port drives straight from flip-flops
   assign prdata = prdata_r;
   assign pready = (bus_r == DLP_BUS_ANSWER);
   assign pslverr = pslverr_r;
   assign wiper0 = wiper_r[0];
   assign wiper1 = wiper_r[1];
   assign amp_en = {stage_r[1][3], stage_r[0][3]};
   assign ladder_en = {stage_r[1][2], stage_r[0][2]};
   assign pull_1k_en = {stage_r[1][1], stage_r[0][1]};
   assign pull_100k_en = {stage_r[1][0], stage_r[0][0]};
   assign cfg_bits = cfg_r;
   assign irq = irq_r;

   // Two-stage synchroniser for the asynchronous hold pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_s1_r <= 1'b0;
         hold_s2_r <= 1'b0;
      end else begin
         hold_s1_r <= update_hold_pin;
         hold_s2_r <= hold_s1_r;
      end
   end

   // APB slave: one wait state, answer always available even in power-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_r <= DLP_BUS_IDLE;
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         case (bus_r)
            DLP_BUS_IDLE: begin
               if (acc_req) begin
                  bus_r <= DLP_BUS_ANSWER;
                  prdata_r <= pwrite ? 32'h00000000 : rd_word;
                  pslverr_r <= !mapped;
               end
            end
            DLP_BUS_ANSWER: begin
               bus_r <= DLP_BUS_IDLE;
               pslverr_r <= 1'b0;
            end
            default: bus_r <= DLP_BUS_IDLE;
         endcase
      end
   end

   // Address pointer keeps the last completed address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_ptr_r <= 8'h00;
      end else if (gc_reset) begin
         addr_ptr_r <= 8'h00;
      end else if (acc_done) begin
         addr_ptr_r <= paddr;
      end
   end

   // Code registers, selectors and configuration bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_r[0] <= `DLP_CODE_RST;
         code_r[1] <= `DLP_CODE_RST;
         pd_r[0] <= `DLP_PD_RST;
         pd_r[1] <= `DLP_PD_RST;
         cfg_r <= `DLP_CFG_RST;
      end else begin
         code_r[0] <= code0_nxt;
         code_r[1] <= code1_nxt;
         pd_r[0] <= pd0_nxt;
         pd_r[1] <= pd1_nxt;
         if (gc_reset) begin
            cfg_r <= `DLP_CFG_RST;
         end else if (wr_done && sel_cfg) begin
            cfg_r <= pwdata[4:0];
         end
      end
   end

   // Wiper transfer, level driven by the hold pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wiper_r[0] <= `DLP_CODE_RST;
         wiper_r[1] <= `DLP_CODE_RST;
      end else begin
         wiper_r[0] <= wiper0_nxt;
         wiper_r[1] <= wiper1_nxt;
      end
   end

   // Output stage per channel; power-down leaves codes and config untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_r[0] <= 4'h0;
         stage_r[1] <= 4'h0;
      end else begin
         stage_r[0] <= stage_of(pd_r[0], por_busy);
         stage_r[1] <= stage_of(pd_r[1], por_busy);
      end
   end

   // Power-on delay timer and status flag; general call reset skips the timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_r <= POR_CNT_INIT;
         por_flag_r <= 1'b1;
      end else begin
         if (por_busy) begin
            por_cnt_r <= por_cnt_r - 8'h01;
         end
         if (rd_done && sel_stat) begin
            por_flag_r <= 1'b0;
         end
      end
   end

   // Interrupt status, mask and level output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= 4'h0;
         irq_mask_r <= `DLP_IRQ_MASK_RST;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= |(irq_stat_nxt & irq_mask_nxt);
      end
   end

   // Checks on the guarded behaviour
   sequence hold_high_s;
      hold_s2_r && $past(hold_s2_r);
   endsequence

   sequence pin_low3_s;
      !update_hold_pin [*3];
   endsequence

   sequence code_write_s;
      wr_done && (sel_code0 || sel_code1);
   endsequence

   hold_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      hold_high_s |-> $stable(wiper_r[0]) && $stable(wiper_r[1]))
      else $error("Wiper moved while hold level was high");

   wiper_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      !hold_s2_r |=> (wiper_r[0] == $past(code_r[0])) && (wiper_r[1] == $past(code_r[1])))
      else $error("Wiper did not follow its code with hold low");

   hold_async_a: assert property (@(posedge pclk) disable iff (!presetn)
      pin_low3_s ##0 !psel |=> wiper_r[0] == $past(code_r[0]))
      else $error("Hold pin release not acted on within three cycles");

   both_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(hold_s2_r) |=> (wiper_r[0] == $past(code_r[0])) && (wiper_r[1] == $past(code_r[1])))
      else $error("Wipers did not load together on hold release");

   pd_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pd_r[0] == 2'h1) |=> pull_1k_en[0] && !pull_100k_en[0] && !amp_en[0])
      else $error("Selector 01 did not choose the 1k pull-down");

   pd_cutoff_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pd_r[1] != 2'h0) |=> !amp_en[1] && !ladder_en[1])
      else $error("Amplifier or ladder left on in power-down");

   pd_source_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pd_r[0] != $past(pd_r[0])) |-> $past(pd_wr || gc_reset || gc_wake))
      else $error("Selector changed without a write or general call");

   por_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_done && sel_stat) |=> !por_flag_r ##1 !por_flag_r)
      else $error("Power-on flag not cleared by status read");

   gc_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      gc_reset |=> (code_r[0] == `DLP_CODE_RST) && (pd_r[1] == 2'h0) && !por_busy)
      else $error("General call reset did not restore defaults");

   bus_live_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_req |=> pready ##1 !pready)
      else $error("Register access not answered in one wait state");

   write_land_a: assert property (@(posedge pclk) disable iff (!presetn)
      code_write_s ##1 !hold_s2_r |=> wiper_r[0] == $past(code_r[0], 1))
      else $error("Completed code write did not reach the wiper");

   // Wake-up returns both channel selectors to normal on the next edge
   gc_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      gc_wake |=> (pd_r[0] == `DLP_PD_RST) && (pd_r[1] == `DLP_PD_RST))
      else $error("Wake-up command did not leave power-down");

   // Interrupt level always matches the unmasked sticky bits
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(irq_stat_r & irq_mask_r))
      else $error("Interrupt level disagrees with unmasked status");

endmodule : dlp_ctrl

/* test/dlp_hold_src.sv */
// Far-side event source that drives the update hold pin
`timescale 1ns/1ps

module dlp_hold_src (
   input wire logic hold_req,
   output logic update_hold_pin
);
   // Pin starts low, so the wipers follow their code registers unless held
   initial update_hold_pin = 1'b0;
   // Pin edges land between clock edges, with no relation to bus traffic
   always @(hold_req) update_hold_pin <= #7 hold_req;
endmodule : dlp_hold_src

/* test/tb.sv */
// Self-checking testbench of the DAC latch and power-down control block
`timescale 1ns/1ps
`include "dlp_map.svh"

module tb;
   import dlp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold_req = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, update_hold_pin, irq;
   logic [11:0] wiper0, wiper1, c0, c1, o0;
   logic [1:0] amp_en, ladder_en, pull_1k_en, pull_100k_en;
   logic [4:0] cfg_bits, cf;
   logic [7:0] stg;
   int bad_count = 0, samples_checked = 0, cycles = 0, s, t, i;
   // Expected read words and compare masks, oldest first
   logic [32:0] exp_q[$], msk_q[$];

   // 40 MHz clock
   always #12.5 pclk = ~pclk;

   dlp_hold_src src (.hold_req(hold_req), .update_hold_pin(update_hold_pin));
   dlp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .update_hold_pin(update_hold_pin), .wiper0(wiper0), .wiper1(wiper1),
      .amp_en(amp_en), .ladder_en(ladder_en), .pull_1k_en(pull_1k_en),
      .pull_100k_en(pull_100k_en), .cfg_bits(cfg_bits), .irq(irq));

   // Compare one value and count it
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Report counts and the verdict, then stop
   task results;
      $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // One APB transfer: setup, access held until pready, then release
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Note the expected {pslverr, prdata} and mask, then read
   task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   // Watcher: each completed read is matched against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         chk({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      void'($urandom(93));
      idle(6);
      presetn <= 1'b1;
      idle(1);
      // Power-on defaults, flag set, pointer zero, drive held off
      chk(33'({amp_en, ladder_en}), 33'h0);
      rd(`DLP_OFF_STAT, 33'h3, 33'hFF03);
      rd(`DLP_OFF_STAT, 33'h0, 33'h1);
      rd(`DLP_OFF_CODE0, 33'h7FF, '1);
      rd(`DLP_OFF_CODE1, 33'h7FF, '1);
      rd(`DLP_OFF_PD, 33'h0, '1);
      rd(`DLP_OFF_CFG, 33'h0, '1);
      rd(8'h30, 33'h1_0000_0000, '1);
      idle(45);
      // Hold low: wiper follows a completed write
      c0 = 12'($urandom);
      wr(`DLP_OFF_CODE0, {20'h0, c0});
      rd(`DLP_OFF_WIPER0, 33'(c0), '1);
      // Hold high: writes land in the codes, wipers freeze
      o0 = c0;
      hold_req <= 1'b1;
      idle(6);
      // Odd xor masks keep the new codes apart from the frozen wiper values
      c0 = o0 ^ (12'($urandom) | 12'h001);
      c1 = `DLP_CODE_RST ^ (12'($urandom) | 12'h001);
      wr(`DLP_OFF_CODE0, {20'h0, c0});
      wr(`DLP_OFF_CODE1, {20'h0, c1});
      rd(`DLP_OFF_CODE0, 33'(c0), '1);
      rd(`DLP_OFF_WIPER0, 33'(o0), '1);
      rd(`DLP_OFF_WIPER1, 33'h7FF, '1);
      // Release with no bus traffic: both wipers change at one moment
      hold_req <= 1'b0;
      for (i = 0; i < 8 && wiper0 !== c0; i++) @(negedge pclk);
      chk(33'(wiper0), 33'(c0));
      chk(33'(wiper1), 33'(c1));
      // Every selector on ch0 against a different one on ch1
      for (s = 0; s < 4; s++) begin
         t = 3 - s;
         wr(`DLP_OFF_PD, {28'h0, t[1:0], s[1:0]});
         idle(2);
         stg = {t == 0, s == 0, t == 0, s == 0, t == 1, s == 1, t == 2, s == 2};
         chk(33'({amp_en, ladder_en, pull_1k_en, pull_100k_en}), 33'(stg));
         rd(`DLP_OFF_CODE0, 33'(c0), '1);
      end
      // Leave power-down by writing zero, then by wake-up command
      wr(`DLP_OFF_PD, 32'h5);
      wr(`DLP_OFF_PD, 32'h0);
      idle(2);
      chk(33'({amp_en, ladder_en}), 33'hF);
      wr(`DLP_OFF_PD, 32'hF);
      wr(`DLP_OFF_CMD, 32'h2);
      rd(`DLP_OFF_PD, 33'h0, '1);
      // Reset command: defaults back, no flag, no delay restart
      cf = 5'($urandom);
      wr(`DLP_OFF_CFG, {27'h0, cf});
      idle(1);
      chk(33'(cfg_bits), 33'(cf));
      wr(`DLP_OFF_PD, 32'hA);
      wr(`DLP_OFF_CMD, 32'h1);
      rd(`DLP_OFF_CODE0, 33'h7FF, '1);
      rd(`DLP_OFF_PD, 33'h0, '1);
      rd(`DLP_OFF_CFG, 33'h0, '1);
      rd(`DLP_OFF_STAT, 33'h0, 33'h3);
      idle(2);
      chk(33'({amp_en, wiper1}), 33'h37FF);
      // Interrupt: masked, unmasked, then cleared
      chk(33'(irq), 33'h0);
      // Wiper change, power-down entry and exit, and reset have all happened by now
      rd(`DLP_OFF_IRQ_STAT, 33'hF, 33'hF);
      wr(`DLP_OFF_IRQ_MASK, 32'h8);
      idle(2);
      chk(33'(irq), 33'h1);
      wr(`DLP_OFF_IRQ_STAT, 32'hF);
      idle(2);
      chk(33'(irq), 33'h0);
      rd(`DLP_OFF_IRQ_STAT, 33'h0, 33'hF);
      idle(4);
      results();
   end
endmodule : tb
